// ---- verilog/mprad_top.sv ----
// top: register address decode for the ten-port mac
// Overview of operation
// - register address is exactly eleven bits
// - split into 7-bit offset, 4-bit selector
// - port n region starts at n*0x80
// - global region above ports up to 0x7ff
// - identical register set for all ten ports
// - tx status updates on chosen tsclk edge
// - rx status sampled on chosen rsclk edge
// - every register is one 32-bit word
module mprad_top
	import mprad_pkg::*;
#(
	parameter int PORTS = MPRAD_PORTS
) (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  mprad_pkg::mprad_req_s             req,
	input  wire logic [PORTS*32-1:0]          port_rdata,
	input  wire logic [31:0]                  glb_rdata,
	input  wire logic                         edge_flip,
	input  wire logic                         tx_stat_clk,
	input  wire logic [1:0]                   tx_stat_in,
	input  wire logic                         rx_stat_clk,
	input  wire logic [1:0]                   rx_stat,
	output mprad_pkg::mprad_dec_s             dec,
	output logic      [31:0]                  rdata,
	output logic                              rvalid,
	output logic      [1:0]                   tx_stat,
	output logic      [1:0]                   rx_stat_smp
);
	import mprad_pkg::*;

	// registered state of the decode stage
	typedef struct packed {
		mprad_dec_s              dec;
		logic [MPRAD_DATA_W-1:0] rdata;
		logic                    rvalid;
	} mprad_top_s;

	logic [1:0]              rst_sync_q;
	logic                    rst_i_b;
	mprad_sel_t              req_sel;
	mprad_ofs_t              req_ofs;
	logic                    req_glb;
	logic [PORTS-1:0]        port_hit;
	logic [MPRAD_DATA_W-1:0] port_word [PORTS];
	logic [MPRAD_DATA_W-1:0] port_mux;
	logic [MPRAD_DATA_W-1:0] glb_word;
	mprad_top_s              st_q;
	mprad_top_s              st_d;

	// selector is the upper four address bits
	function automatic mprad_sel_t sel_of(
		input logic [MPRAD_ADDR_W-1:0] a
	);
		sel_of = a[MPRAD_SEL_MSB:MPRAD_SEL_LSB];
	endfunction : sel_of

	// offset is the word inside one region
	function automatic mprad_ofs_t ofs_of(
		input logic [MPRAD_ADDR_W-1:0] a
	);
		ofs_of = a[MPRAD_OFS_W-1:0];
	endfunction : ofs_of

	// selectors past the last port fall into the global area
	function automatic logic sel_is_glb(
		input mprad_sel_t s
	);
		sel_is_glb = (32'(s) >= PORTS);
	endfunction : sel_is_glb

	// selector picks port n
	function automatic logic sel_is_port(
		input mprad_sel_t s,
		input int         n
	);
		sel_is_port = (32'(s) == n);
	endfunction : sel_is_port

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_i_b = rst_sync_q[1];

	// the whole eleven-bit address is split, nothing is dropped
	assign req_sel = sel_of(req.addr);
	assign req_ofs = ofs_of(req.addr);
	assign req_glb = sel_is_glb(req_sel);

	// one identical slice per port, base at n times the stride
	genvar g;
	generate
		for (g = 0; g < PORTS; g = g + 1) begin : g_port
			assign port_hit[g] = sel_is_port(req_sel, g);
			assign port_word[g] = port_hit[g] ?
				port_rdata[g*MPRAD_DATA_W +: MPRAD_DATA_W] :
				MPRAD_ZERO_WORD;
		end
	endgenerate

	// at most one slice is non-zero, so an or merges them
	always_comb begin
		port_mux = MPRAD_ZERO_WORD;
		for (int i = 0; i < PORTS; i++) begin
			port_mux = port_mux | port_word[i];
		end
	end

	assign glb_word = req_glb ? glb_rdata : MPRAD_ZERO_WORD;

	always_comb begin
		st_d              = st_q;
		st_d.dec.port_sel = port_hit;
		st_d.dec.glb_sel  = req_glb;
		st_d.dec.rd       = req.rd;
		st_d.dec.wr       = req.wr;
		st_d.dec.ofs      = req_ofs;
		st_d.dec.wdata    = req.wdata;
		st_d.rvalid       = req.rd;
		if (req.rd) begin
			st_d.rdata = port_mux | glb_word;
		end else begin
			st_d.rdata = MPRAD_ZERO_WORD;
		end
	end

	always_ff @(posedge clk or negedge rst_i_b) begin
		if (!rst_i_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dec    = st_q.dec;
	assign rdata  = st_q.rdata;
	assign rvalid = st_q.rvalid;

	mprad_fifo_stat_edge u_stat (
		.clk         (clk),
		.rst_b       (rst_i_b),
		.edge_flip   (edge_flip),
		.tx_stat_clk (tx_stat_clk),
		.tx_stat_in  (tx_stat_in),
		.rx_stat_clk (rx_stat_clk),
		.rx_stat     (rx_stat),
		.tx_stat     (tx_stat),
		.rx_stat_smp (rx_stat_smp)
	);
endmodule : mprad_top

// ---- verilog/mprad_pkg.sv ----
// package of constants and carriers for the multiport register address decode
package mprad_pkg;
	localparam int          MPRAD_ADDR_W    = 11;
	localparam int          MPRAD_OFS_W     = 7;
	localparam int          MPRAD_SEL_W     = 4;
	localparam int          MPRAD_DATA_W    = 32;
	localparam int          MPRAD_PORTS     = 10;
	localparam int          MPRAD_SEL_LSB   = 7;
	localparam int          MPRAD_SEL_MSB   = 10;
	localparam logic [10:0] MPRAD_PORT_STRIDE = 11'h080;
	localparam logic [10:0] MPRAD_GLOBAL_BASE = 11'h500;
	localparam logic [10:0] MPRAD_ADDR_TOP  = 11'h7ff;
	localparam logic [31:0] MPRAD_ZERO_WORD = 32'h0000_0000;

	typedef logic [MPRAD_OFS_W-1:0] mprad_ofs_t;
	typedef logic [MPRAD_SEL_W-1:0] mprad_sel_t;

	// host access request
	typedef struct packed {
		logic                    rd;
		logic                    wr;
		logic [MPRAD_ADDR_W-1:0] addr;
		logic [MPRAD_DATA_W-1:0] wdata;
	} mprad_req_s;

	// decoded access towards the register storage
	typedef struct packed {
		logic [MPRAD_PORTS-1:0]  port_sel;
		logic                    glb_sel;
		logic                    rd;
		logic                    wr;
		mprad_ofs_t              ofs;
		logic [MPRAD_DATA_W-1:0] wdata;
	} mprad_dec_s;
endpackage : mprad_pkg

// ---- verilog/mprad_fifo_stat_edge.sv ----
// fifo status lines with selectable active edge
module mprad_fifo_stat_edge (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       edge_flip,
	input  wire logic       tx_stat_clk,
	input  wire logic [1:0] tx_stat_in,
	input  wire logic       rx_stat_clk,
	input  wire logic [1:0] rx_stat,
	output logic      [1:0] tx_stat,
	output logic      [1:0] rx_stat_smp
);
	typedef struct packed {
		logic       tclk;
		logic       rclk;
		logic [1:0] tx;
		logic [1:0] rx;
	} mprad_edge_s;

	mprad_edge_s st_q;
	mprad_edge_s st_d;
	logic        t_rise;
	logic        t_fall;
	logic        r_rise;
	logic        r_fall;

	always_comb begin
		st_d      = st_q;
		st_d.tclk = tx_stat_clk;
		st_d.rclk = rx_stat_clk;
		t_rise    = tx_stat_clk & ~st_q.tclk;
		t_fall    = ~tx_stat_clk & st_q.tclk;
		r_rise    = rx_stat_clk & ~st_q.rclk;
		r_fall    = ~rx_stat_clk & st_q.rclk;
		if (edge_flip ? t_fall : t_rise) begin
			st_d.tx = tx_stat_in;
		end
		if (edge_flip ? r_fall : r_rise) begin
			st_d.rx = rx_stat;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tx_stat     = st_q.tx;
	assign rx_stat_smp = st_q.rx;
endmodule : mprad_fifo_stat_edge

// ---- verif/mprad_chk.sv ----
// checker for decode timing, read data and status edges
module mprad_chk import mprad_pkg::*; #(parameter int PORTS = MPRAD_PORTS) (
	input wire logic [0:0]          clk,
	input wire logic [0:0]          rst_b,
	input mprad_req_s               req,
	input wire logic [PORTS*32-1:0] port_rdata,
	input wire logic [31:0]         glb_rdata,
	input wire logic [0:0]          edge_flip,
	input wire logic [0:0]          tx_stat_clk,
	input wire logic [1:0]          tx_stat_in,
	input wire logic [0:0]          rx_stat_clk,
	input wire logic [1:0]          rx_stat,
	input mprad_dec_s               dec,
	input wire logic [31:0]         rdata,
	input wire logic [0:0]          rvalid,
	input wire logic [1:0]          tx_stat,
	input wire logic [1:0]          rx_stat_smp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic [3:0]  sel = req.addr[10:7];
	wire logic        acc = req.rd | req.wr;
	wire logic [31:0] word = sel < PORTS ? port_rdata[sel*32+:32] : glb_rdata;
	ofs_field_a: assert property (acc |=>
		dec.ofs == $past(req.addr[6:0])) else $error("offset");
	port_sel_a: assert property (acc && sel < PORTS |=>
		dec.port_sel[$past(sel)] && $onehot(dec.port_sel)) else $error("port");
	glb_sel_a: assert property (acc && sel >= PORTS |=>
		dec.glb_sel && dec.port_sel == 0) else $error("global");
	rd_word_a: assert property (req.rd |=>
		rvalid && rdata == $past(word)) else $error("read word");
	idle_zero_a: assert property (!req.rd |=>
		!rvalid && rdata == 0) else $error("idle data");
	wr_word_a: assert property (req.wr |=>
		dec.wr && dec.wdata == $past(req.wdata)) else $error("write");
	tx_edge_a: assert property ($changed(tx_stat_clk) &&
		(edge_flip ^ tx_stat_clk) |=> tx_stat == $past(tx_stat_in))
		else $error("tx status");
	rx_edge_a: assert property ($changed(rx_stat_clk) &&
		(edge_flip ^ rx_stat_clk) |=> rx_stat_smp == $past(rx_stat))
		else $error("rx status");
	cover property (req.rd && sel == 4'h9);
	cover property (req.wr && sel == 4'hf);
	cover property (edge_flip && $fell(rx_stat_clk));
endmodule : mprad_chk
bind mprad_top mprad_chk #(.PORTS(PORTS)) mprad_chk_i (
	.clk(clk), .rst_b(rst_b), .req(req), .port_rdata(port_rdata),
	.glb_rdata(glb_rdata), .edge_flip(edge_flip),
	.tx_stat_clk(tx_stat_clk), .tx_stat_in(tx_stat_in),
	.rx_stat_clk(rx_stat_clk), .rx_stat(rx_stat), .dec(dec),
	.rdata(rdata), .rvalid(rvalid), .tx_stat(tx_stat),
	.rx_stat_smp(rx_stat_smp)
);

// ---- verif/multiport_register_address_decode_tb.sv ----
// bench: address map, back-to-back accesses and status edges
module multiport_register_address_decode_tb import mprad_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic                      clk = 0, rst_b = 0, edge_flip = 0, rvalid;
	logic                      tx_stat_clk = 0, rx_stat_clk = 0;
	logic [1:0]                tx_stat_in = 0, rx_stat = 0, et = 0, er = 0;
	logic [1:0]                tx_stat, rx_stat_smp;
	logic [MPRAD_PORTS*32-1:0] port_rdata;
	logic [31:0]               glb_rdata = 32'hc0de_0011, rdata;
	mprad_req_s                req = '0;
	mprad_dec_s                dec;
	int                        failures = 0, checked = 0;
	mprad_top mprad_top_i (
		.clk(clk), .rst_b(rst_b), .req(req), .port_rdata(port_rdata),
		.glb_rdata(glb_rdata), .edge_flip(edge_flip),
		.tx_stat_clk(tx_stat_clk), .tx_stat_in(tx_stat_in),
		.rx_stat_clk(rx_stat_clk), .rx_stat(rx_stat), .dec(dec),
		.rdata(rdata), .rvalid(rvalid), .tx_stat(tx_stat),
		.rx_stat_smp(rx_stat_smp)
	);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("Error %0t %h %h", $time, s, e);
		end
	endtask : chk
	task automatic close_out;
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	task automatic acc(input logic r, w, input logic [10:0] a, input logic [31:0] d);
		logic [3:0] s;
		s = a[10:7];
		req = '{r, w, a, d};
		@(negedge clk);
		chk({dec.glb_sel, dec.port_sel, dec.ofs, dec.rd, dec.wr, rvalid},
			{s > 9, s > 9 ? 10'h0 : 10'h1 << s, a[6:0], r, w, r});
		chk(rdata, r ? (s > 9 ? glb_rdata : port_rdata[s*32+:32]) : 0);
		if (w) chk(dec.wdata, d);
	endtask : acc
	task automatic t_read;
		for (int n = 0; n < 16; n++) begin
			acc(1, 0, {n[3:0], n[0] ? 7'h7f : 7'h00}, 0);
		end
	endtask : t_read
	task automatic t_write;
		acc(0, 1, 11'h7ff, 32'ha5a5_5a5a);
		acc(0, 1, 11'h480, 32'h0123_4567);
		acc(1, 0, 11'h000, 0);
		req = '0;
		@(negedge clk);
		chk(rdata, 0);
	endtask : t_write
	task automatic t_stat;
		for (int i = 0; i < 8; i++) begin
			edge_flip = i[2];
			tx_stat_in = i[1:0];
			rx_stat = ~i[1:0];
			tx_stat_clk = ~tx_stat_clk;
			rx_stat_clk = ~rx_stat_clk;
			if (tx_stat_clk != edge_flip) begin
				et = i[1:0];
				er = ~i[1:0];
			end
			repeat (2) @(negedge clk);
			chk(tx_stat, et);
			chk(rx_stat_smp, er);
		end
	endtask : t_stat
	initial begin
		for (int i = 0; i < MPRAD_PORTS; i++) port_rdata[i*32+:32] = 32'h1000_0000 + i;
		repeat (6) @(negedge clk);
		rst_b = 1;
		repeat (3) @(negedge clk);
		t_read();
		t_write();
		t_stat();
		close_out();
	end
	initial begin
		#2000;
		failures++;
		close_out();
	end
endmodule : multiport_register_address_decode_tb
